// *** ext_irq_pkg.sv ***
/*
 * Package for the external interrupt and vector placement block: register
 * offsets, field positions, reset values, sense encodings and timing counts.
 * Assumes an 8-bit I/O register port from the processor core.
 */
package ext_irq_pkg;
   // ****************************************
   // Register offsets (I/O space)
   // ****************************************
   localparam logic [7:0] IO_SPACE_MAX = 8'h3f;
   localparam logic [7:0] DATA_SPACE_BIAS = 8'h20;
   localparam logic [5:0] OFS_STATUS_CTRL = 6'h34;
   localparam logic [5:0] OFS_SENSE_CTRL = 6'h35;
   localparam logic [5:0] OFS_IRQ_FLAGS = 6'h3a;
   localparam logic [5:0] OFS_IRQ_CTRL = 6'h3b;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int BIT_UNLOCK = 0;
   localparam int BIT_VSEL = 1;
   localparam int BIT_PIN2 = 5;
   localparam int BIT_PIN0 = 6;
   localparam int BIT_PIN1 = 7;
   localparam int BIT_SENSE2 = 6;
   localparam int SENSE0_LSB = 0;
   localparam int SENSE1_LSB = 2;

   // ****************************************
   // Sense encodings and timing
   // ****************************************
   typedef enum logic [1:0] {
      SENSE_LOW = 2'h0,
      SENSE_ANY = 2'h1,
      SENSE_FALL = 2'h2,
      SENSE_RISE = 2'h3
   } sense_t;

   localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
   localparam int BOOT_FUSE_W = 2;
   localparam int VEC_ADDR_W = 15;

   typedef struct packed {
      logic wr;
      logic rd;
      logic data_space;
      logic [7:0] addr;
      logic [7:0] wdata;
   } io_req_t;
endpackage

// *** ext_irq_edge.sv ***
/*
 * Clocked edge/level detector for one sensed pin.
 * Assumes the pin is already synchronised to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module ext_irq_edge (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_pin,
   input wire ext_irq_pkg::sense_t i_sense,
   output logic o_event
);
   import ext_irq_pkg::*;
   logic prev_reg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_reg <= 1'b1;
      end else begin
         prev_reg <= i_pin;
      end
   end

   always_comb begin
      case (i_sense)
         SENSE_LOW: o_event = !i_pin;
         SENSE_ANY: o_event = i_pin ^ prev_reg;
         SENSE_FALL: o_event = prev_reg & !i_pin;
         SENSE_RISE: o_event = !prev_reg & i_pin;
         default: o_event = 1'b0;
      endcase
   end
endmodule // ext_irq_edge
`default_nettype wire

// *** ext_irq_ctrl.sv ***
/*
 * External interrupt control for three pins plus vector table placement,
 * with timed unlock of the vector select and automatic interrupt blocking.
 * Assumes an 8-bit I/O register port from the core (I/O or data space
 * addressing), a vector-taken strobe per pin, and a slow wake sample clock
 * presented as a plain input that is synchronised here.
 */
// Function
// RULE1 - Select bit picks flash or boot vectors
// RULE2 - Boot base derived from boot-size fuses
// RULE3 - Software unlocks then writes within four
// RULE4 - Block interrupts from unlock until after write
// RULE5 - Unwritten unlock blocks four cycles only
// RULE6 - Blocking leaves global enable bit untouched
// RULE7 - Unlock clears after four or on write
// RULE8 - Boot lock bits block cross-section interrupts
// RULE9 - Pin triggers even when driven as output
// RULE10 - Third pin is edge-only
// RULE11 - Level mode requests while pin low
// RULE12 - Clocked edges; async low level, pin2 edges
// RULE13 - I/O clock stops outside idle sleep
// RULE14 - Wake level sampled twice by watchdog clock
// RULE15 - Vanished wake level wakes without interrupt
// RULE16 - Sense field one bits 3:2 encoding
// RULE17 - Sense field zero bits 1:0 encoding
// RULE18 - Pins sampled before edge detection
// RULE19 - Source holds low until instruction ends
// RULE20 - Forward only with global and pin enable
// RULE21 - I/O addresses plus data-space offset 0x20
// RULE22 - Flags set, cleared on vector or write-one
// RULE23 - Level-mode flag reads as cleared
// RULE24 - Status bit six picks pin2 edge
// RULE25 - Enables at bits 7, 6, 5
// RULE26 - Two-stage synchroniser before edge compare
`timescale 1ns/1ps
`default_nettype none
module ext_irq_ctrl #(
   parameter int BOOT_BASE_0 = 'h3800,
   parameter int BOOT_BASE_1 = 'h3c00,
   parameter int BOOT_BASE_2 = 'h3e00,
   parameter int BOOT_BASE_3 = 'h3f00
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire ext_irq_pkg::io_req_t i_io,
   input wire logic [2:0] i_pins,
   input wire logic [2:0] i_vector_taken,
   input wire logic i_global_irq_enable,
   input wire logic i_exec_in_boot,
   input wire logic i_boot_lock_app_irq,
   input wire logic i_boot_lock_boot_irq,
   input wire logic [ext_irq_pkg::BOOT_FUSE_W-1:0] i_boot_size_fuses,
   input wire logic i_instr_done,
   input wire logic i_sleep_deep,
   input wire logic i_wdt_clk,
   input wire logic i_startup_done,
   output logic [7:0] o_rdata,
   output logic [2:0] o_irq_req,
   output logic o_wake,
   output logic [ext_irq_pkg::VEC_ADDR_W-1:0] o_vector_base
);
   import ext_irq_pkg::*;

   // ****************************************
   // Reset release and synchronisers
   // ****************************************
   logic rst_meta_reg, rst_n;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // Pin sampled even when driven as output, so software can self-interrupt
   logic [2:0] pin_meta_reg, pin_sync_reg;
   logic wdt_meta_reg, wdt_sync_reg;
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_reg <= 3'h7;
         pin_sync_reg <= 3'h7;
         wdt_meta_reg <= 1'b0;
         wdt_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= i_pins; // RULE9 RULE18 RULE26
         pin_sync_reg <= pin_meta_reg; // RULE26
         wdt_meta_reg <= i_wdt_clk;
         wdt_sync_reg <= wdt_meta_reg;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   logic [1:0] sense0_reg, sense1_reg;
   logic sense2_reg;
   logic [2:0] enable_reg, flag_reg;
   logic vsel_reg, unlock_reg;
   logic [2:0] unlock_cnt_reg;
   logic hold_reg;
   logic [5:0] ofs;
   logic hit, wr_sense, wr_stat, wr_ctrl, wr_flags;

   // Data-space accesses carry the 0x20 bias
   always_comb begin
      ofs = i_io.data_space ? 6'(i_io.addr - DATA_SPACE_BIAS) : i_io.addr[5:0]; // RULE21
      hit = i_io.data_space ? (i_io.addr >= DATA_SPACE_BIAS &&
                               i_io.addr <= IO_SPACE_MAX + DATA_SPACE_BIAS)
                            : (i_io.addr <= IO_SPACE_MAX); // RULE21
      wr_sense = i_io.wr && hit && ofs == OFS_SENSE_CTRL;
      wr_stat = i_io.wr && hit && ofs == OFS_STATUS_CTRL;
      wr_ctrl = i_io.wr && hit && ofs == OFS_IRQ_CTRL;
      wr_flags = i_io.wr && hit && ofs == OFS_IRQ_FLAGS;
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sense0_reg <= RESET_BYTE[1:0];
         sense1_reg <= RESET_BYTE[1:0];
         sense2_reg <= 1'b0;
      end else begin
         if (wr_sense) begin
            sense0_reg <= i_io.wdata[SENSE0_LSB +: 2]; // RULE17
            sense1_reg <= i_io.wdata[SENSE1_LSB +: 2]; // RULE16
         end
         if (wr_stat) begin
            sense2_reg <= i_io.wdata[BIT_SENSE2]; // RULE24
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_reg <= RESET_BYTE[2:0];
      end else if (wr_ctrl) begin
         enable_reg <= {i_io.wdata[BIT_PIN2], i_io.wdata[BIT_PIN1], i_io.wdata[BIT_PIN0]}; // RULE25
      end
   end

   // ****************************************
   // Vector select unlock sequence
   // ****************************************
   // Select write only counts while unlocked and with the unlock bit written zero
   logic vsel_write;
   assign vsel_write = wr_ctrl && unlock_reg && !i_io.wdata[BIT_UNLOCK];

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_reg <= 1'b0;
         unlock_cnt_reg <= 3'h0;
         vsel_reg <= 1'b0;
      end else begin
         if (wr_ctrl && i_io.wdata[BIT_UNLOCK]) begin
            unlock_reg <= 1'b1;
            unlock_cnt_reg <= UNLOCK_CYCLES;
         end else if (vsel_write) begin
            unlock_reg <= 1'b0; // RULE7
            unlock_cnt_reg <= 3'h0;
            vsel_reg <= i_io.wdata[BIT_VSEL]; // RULE3
         end else if (unlock_cnt_reg != 3'h0) begin
            unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
            if (unlock_cnt_reg == 3'h1) begin
               unlock_reg <= 1'b0; // RULE7 RULE5
            end
         end
      end
   end

   // Blocking extends past the select write until the next instruction-end strobe
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_reg <= 1'b0;
      end else if (vsel_write) begin
         hold_reg <= 1'b1; // RULE4
      end else if (i_instr_done) begin
         hold_reg <= 1'b0;
      end
   end

   // Blocking is local; the core's global enable is only read, never written
   logic auto_block;
   assign auto_block = unlock_reg || hold_reg || (wr_ctrl && i_io.wdata[BIT_UNLOCK]); // RULE4 RULE6

   // ****************************************
   // Vector base from fuses
   // ****************************************
   logic [VEC_ADDR_W-1:0] boot_base;
   always_comb begin
      case (i_boot_size_fuses)
         2'h0: boot_base = VEC_ADDR_W'(BOOT_BASE_0); // RULE2
         2'h1: boot_base = VEC_ADDR_W'(BOOT_BASE_1);
         2'h2: boot_base = VEC_ADDR_W'(BOOT_BASE_2);
         default: boot_base = VEC_ADDR_W'(BOOT_BASE_3);
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_vector_base <= '0;
      end else begin
         o_vector_base <= vsel_reg ? boot_base : '0; // RULE1
      end
   end

   // ****************************************
   // Detection
   // ****************************************
   logic [2:0] evt;
   sense_t sense_sel [2];
   assign sense_sel[0] = sense_t'(sense0_reg);
   assign sense_sel[1] = sense_t'(sense1_reg);

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_det
         // Clocked edges; in deep sleep only the level path is honoured
         ext_irq_edge u_edge (
            .i_clk(i_clk),
            .i_rst_n(rst_n),
            .i_pin(pin_sync_reg[g]),
            .i_sense(sense_sel[g]),
            .o_event(evt[g])
         ); // RULE12 RULE11
      end
   endgenerate

   // Pin 2 is edge-only; falling or rising per sense bit
   ext_irq_edge u_edge2 (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_pin(pin_sync_reg[2]),
      .i_sense(sense2_reg ? SENSE_RISE : SENSE_FALL),
      .o_event(evt[2])
   ); // RULE10 RULE12

   logic [2:0] level_mode;
   assign level_mode = {1'b0, sense1_reg == SENSE_LOW, sense0_reg == SENSE_LOW};

   // ****************************************
   // Flags
   // ****************************************
   // Pin 2 stands for an asynchronous catch, so it still flags in deep sleep
   for (g = 0; g < 3; g++) begin : g_flag
      always_ff @(posedge i_clk or negedge rst_n) begin
         if (!rst_n) begin
            flag_reg[g] <= 1'b0;
         end else if (level_mode[g]) begin
            flag_reg[g] <= 1'b0; // RULE23
         end else if (evt[g] && (!i_sleep_deep || g == 2)) begin
            flag_reg[g] <= 1'b1; // RULE22 RULE13 RULE12
         end else if (i_vector_taken[g] || (wr_flags &&
                      i_io.wdata[g == 0 ? BIT_PIN0 : (g == 1 ? BIT_PIN1 : BIT_PIN2)])) begin
            flag_reg[g] <= 1'b0; // RULE22
         end
      end
   end

   // ****************************************
   // Wake-up and requests
   // ****************************************
   // Two watchdog-clock samples of the low level, counted on its rising edges
   logic wdt_prev_reg;
   logic [1:0] wake_cnt_reg;
   logic wake_pending_reg;
   logic [2:0] level_req;
   assign level_req = level_mode & ~pin_sync_reg; // RULE11 RULE19

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_prev_reg <= 1'b0;
         wake_cnt_reg <= 2'h0;
         o_wake <= 1'b0;
         wake_pending_reg <= 1'b0;
      end else begin
         wdt_prev_reg <= wdt_sync_reg;
         if (!i_sleep_deep) begin
            wake_cnt_reg <= 2'h0;
            o_wake <= 1'b0;
            wake_pending_reg <= 1'b0;
         end else if ((level_req & enable_reg) == 3'h0 && !(flag_reg[2] && enable_reg[2])) begin
            wake_cnt_reg <= 2'h0;
         end else if (wdt_sync_reg && !wdt_prev_reg) begin
            if (wake_cnt_reg == 2'h1 || flag_reg[2]) begin
               o_wake <= 1'b1; // RULE14 RULE12
               wake_pending_reg <= 1'b1;
            end else begin
               wake_cnt_reg <= wake_cnt_reg + 2'h1; // RULE14
            end
         end
      end
   end

   // Vector-section lock and automatic blocking gate every request
   logic section_block, irq_ok;
   assign section_block = (vsel_reg && i_boot_lock_app_irq && !i_exec_in_boot) ||
                          (!vsel_reg && i_boot_lock_boot_irq && i_exec_in_boot); // RULE8
   assign irq_ok = i_global_irq_enable && !auto_block && !section_block; // RULE20

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_irq_req <= 3'h0;
      end else if (wake_pending_reg && !i_startup_done) begin
         o_irq_req <= 3'h0; // RULE15
      end else begin
         o_irq_req <= (flag_reg | level_req) & enable_reg & {3{irq_ok}}; // RULE20 RULE15
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   logic [7:0] rd_next;
   always_comb begin
      rd_next = RESET_BYTE;
      if (i_io.rd && hit) begin
         case (ofs)
            OFS_SENSE_CTRL: rd_next = {4'h0, sense1_reg, sense0_reg};
            OFS_STATUS_CTRL: rd_next = {1'b0, sense2_reg, 6'h00};
            OFS_IRQ_CTRL: rd_next = {enable_reg[1], enable_reg[0], enable_reg[2], 3'h0, vsel_reg, unlock_reg};
            OFS_IRQ_FLAGS: rd_next = {flag_reg[1], flag_reg[0], flag_reg[2], 5'h00};
            default: rd_next = RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= RESET_BYTE;
      end else begin
         o_rdata <= rd_next;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   unlock_timeout_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      $rose(unlock_reg) && !vsel_write ##1 !vsel_write [*3] |-> ##1 !unlock_reg) // RULE7
      else $error("unlock bit outlived its window");
   block_during_unlock_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      unlock_reg |-> ##1 o_irq_req == 3'h0) // RULE4
      else $error("request passed during unlock");
   vsel_needs_unlock_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      !$past(unlock_reg) |-> $stable(vsel_reg)) // RULE3
      else $error("vector select changed without unlock");
   gate_enable_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_irq_req != 3'h0 |-> $past(i_global_irq_enable)) // RULE20
      else $error("request without global enable");
   level_flag_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      $past(level_mode[0]) |-> !flag_reg[0]) // RULE23
      else $error("level mode flag set");
   base_sel_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      !$past(vsel_reg) |-> o_vector_base == '0) // RULE1
      else $error("vector base not flash start");
   pin2_edge_only_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      $rose(flag_reg[2]) |-> $past(pin_sync_reg[2]) != $past(pin_sync_reg[2], 2)) // RULE10
      else $error("pin2 flag set without an edge");
   section_lock_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      section_block |=> o_irq_req == 3'h0) // RULE8
      else $error("request across locked section");
endmodule // ext_irq_ctrl
`default_nettype wire

// *** core_model.sv ***
/*
 * Core-side partner: instruction-end strobes and vector acknowledges.
 * Assumes one clock shared with the interrupt block.
 */
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic i_clk,
   input wire logic [2:0] i_irq_req,
   input wire logic i_ack_en,
   output logic [2:0] o_vector_taken,
   output logic o_instr_done
);
   logic [1:0] phase_reg;

   initial begin
      phase_reg = 2'h0;
      o_vector_taken = 3'h0;
      o_instr_done = 1'b0;
   end

   // ****************************************
   // Instruction pacing and vector fetch
   // ****************************************
   // Four-cycle instructions, so blocking after a select write is visible
   always @(posedge i_clk) begin
      phase_reg <= phase_reg + 2'h1;
      o_instr_done <= (phase_reg == 2'h3);
   end

   // Lowest pending pin taken first; idle cycle between takes avoids a double fetch
   always @(posedge i_clk) begin
      o_vector_taken <= (i_ack_en && o_vector_taken == 3'h0) ? (i_irq_req & (~i_irq_req + 3'h1)) : 3'h0;
   end
endmodule // core_model
`default_nettype wire

// *** testbench.sv ***
/*
 * Self-checking bench for the external interrupt and vector placement block.
 * Assumes the core partner in core_model and a 125 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ext_irq_pkg::*;
   localparam int BASES [4] = '{'h3800, 'h3c00, 'h3e00, 'h3f00};
   logic clk, reset_n, gie, in_boot, lock_app, lock_boot, sleep_deep, wdt_clk, startup_done, ack_en;
   logic [2:0] pins, irq_req, vtaken;
   logic [1:0] fuses;
   logic [7:0] rdata;
   logic wake, idone;
   logic [14:0] vbase;
   io_req_t io;
   int error_cnt = 0;
   int samples_checked = 0;

   ext_irq_ctrl #(.BOOT_BASE_0(BASES[0]), .BOOT_BASE_1(BASES[1]), .BOOT_BASE_2(BASES[2]),
      .BOOT_BASE_3(BASES[3])) ext_irq_ctrl_inst (.i_clk(clk), .i_reset_n(reset_n), .i_io(io),
      .i_pins(pins), .i_vector_taken(vtaken), .i_global_irq_enable(gie), .i_exec_in_boot(in_boot),
      .i_boot_lock_app_irq(lock_app), .i_boot_lock_boot_irq(lock_boot), .i_boot_size_fuses(fuses),
      .i_instr_done(idone), .i_sleep_deep(sleep_deep), .i_wdt_clk(wdt_clk),
      .i_startup_done(startup_done), .o_rdata(rdata), .o_irq_req(irq_req), .o_wake(wake),
      .o_vector_base(vbase));
   core_model core_model_inst (.i_clk(clk), .i_irq_req(irq_req), .i_ack_en(ack_en),
      .o_vector_taken(vtaken), .o_instr_done(idone));

   always #4 clk = ~clk;

   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [14:0] e, input logic [14:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) io <= '{wr: 1'b1, rd: 1'b0, data_space: 1'b0, addr: a, wdata: d};
      @(posedge clk) io <= '0;
   endtask

   task automatic rd_chk(input logic ds, input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) io <= '{wr: 1'b0, rd: 1'b1, data_space: ds, addr: a, wdata: 8'h00};
      @(posedge clk) io <= '0;
      #1 chk("rdata", e, rdata);
   endtask

   // Bounded wait; a hang here ends the run as a failure
   task automatic wait_req(input int p, input logic e);
      int n;
      #1 n = 0;
      while (irq_req[p] !== e && n < 12) begin
         @(posedge clk);
         #1 n++;
      end
      if (irq_req[p] !== e) begin
         error_cnt++;
         $display("MISMATCH irq_req expected %h seen %h", e, irq_req[p]);
         print_verdict();
      end
      samples_checked++;
   endtask

   task automatic settle_chk(input int p, input logic e);
      repeat (8) @(posedge clk);
      #1 chk("irq_req", e, irq_req[p]);
   endtask

   // Fall then rise, with flags cleared after each half
   task automatic pulse_chk(input int p, input logic ef, input logic er);
      @(posedge clk) pins[p] <= 1'b0;
      settle_chk(p, ef);
      wr(8'h3a, 8'he0);
      @(posedge clk) pins[p] <= 1'b1;
      settle_chk(p, er);
      wr(8'h3a, 8'he0);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      clk = 0; reset_n = 0; io = '0; pins = 3'h7; gie = 1; in_boot = 0; lock_app = 0; lock_boot = 0;
      fuses = 2'h1; sleep_deep = 0; wdt_clk = 0; startup_done = 1; ack_en = 0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(1'b0, 8'h34, 8'h00);
      rd_chk(1'b0, 8'h35, 8'h00);
      rd_chk(1'b0, 8'h3a, 8'h00);
      rd_chk(1'b0, 8'h3b, 8'h00);
      rd_chk(1'b0, 8'h10, 8'h00);
      chk("vector_base", 15'h0000, vbase);
      wr(8'h35, 8'h0e);
      rd_chk(1'b1, 8'h55, 8'h0e);
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 4; m++) begin
            wr(8'h35, 8'(m << (2 * p)));
            wr(8'h3b, 8'(8'h40 << p));
            wr(8'h3a, 8'he0);
            pulse_chk(p, m != 3, m[0]);
         end
      end
      for (int e = 0; e < 2; e++) begin
         wr(8'h34, 8'(e << 6));
         wr(8'h3b, 8'h20);
         wr(8'h3a, 8'he0);
         pulse_chk(2, e == 0, e == 1);
      end
      // Masked by global enable, then acknowledged by the core
      wr(8'h35, 8'h02);
      wr(8'h3b, 8'h40);
      wr(8'h3a, 8'he0);
      @(posedge clk) gie <= 1'b0;
      pins[0] <= 1'b0;
      settle_chk(0, 1'b0);
      rd_chk(1'b0, 8'h3a, 8'h40);
      @(posedge clk) gie <= 1'b1;
      wait_req(0, 1'b1);
      @(posedge clk) ack_en <= 1'b1;
      wait_req(0, 1'b0);
      rd_chk(1'b0, 8'h3a, 8'h00);
      @(posedge clk) ack_en <= 1'b0;
      pins[0] <= 1'b1;
      // Level request held low across many instructions
      wr(8'h35, 8'h00);
      @(posedge clk) pins[0] <= 1'b0;
      settle_chk(0, 1'b1);
      rd_chk(1'b0, 8'h3a, 8'h00);
      wr(8'h3b, 8'h41);
      repeat (2) @(posedge clk);
      #1 chk("irq_req", 15'h0, irq_req[0]);
      wait_req(0, 1'b1);
      wr(8'h3b, 8'h42);
      repeat (2) @(posedge clk);
      #1 chk("vector_base", 15'h0000, vbase);
      wr(8'h3b, 8'h41);
      wr(8'h3b, 8'h42);
      #1 chk("irq_req", 15'h0, irq_req[0]);
      repeat (2) @(posedge clk);
      #1 chk("vector_base", 15'(BASES[1]), vbase);
      wait_req(0, 1'b1);
      rd_chk(1'b0, 8'h3b, 8'h42);
      for (int f = 0; f < 4; f++) begin
         @(posedge clk) fuses <= 2'(f);
         repeat (3) @(posedge clk);
         #1 chk("vector_base", 15'(BASES[f]), vbase);
      end
      @(posedge clk) lock_app <= 1'b1;
      settle_chk(0, 1'b0);
      @(posedge clk) in_boot <= 1'b1;
      settle_chk(0, 1'b1);
      @(posedge clk) lock_app <= 1'b0;
      wr(8'h3b, 8'h41);
      wr(8'h3b, 8'h40);
      @(posedge clk) lock_boot <= 1'b1;
      settle_chk(0, 1'b0);
      #1 chk("vector_base", 15'h0000, vbase);
      @(posedge clk) in_boot <= 1'b0;
      settle_chk(0, 1'b1);
      // Deep sleep wake on a level that vanishes before start-up ends
      @(posedge clk) sleep_deep <= 1'b1;
      startup_done <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         repeat (8) @(posedge clk) wdt_clk <= 1'b1;
         repeat (8) @(posedge clk) wdt_clk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      #1 chk("wake", 15'h1, wake);
      chk("irq_req", 15'h0, irq_req[0]);
      @(posedge clk) pins[0] <= 1'b1;
      repeat (6) @(posedge clk) startup_done <= 1'b1;
      sleep_deep <= 1'b0;
      settle_chk(0, 1'b0);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
